// *** hdl/supply_monitor_reset_sequencer.sv ***
/*
 * power-on reset sequencer: holds the device in reset until all monitored
 * rails have tripped, then releases after a standard or fast delay, or at
 * once with instant-on. watches for brown-out in user mode.
 * assumes trip inputs and option pins are synchronous to clk_sys.
 */
// Summary of operation
// - hold reset until every monitored rail is up within the ramp window
// - on a missed ramp window keep pins and programming registers high-z
// - monitor core, auxiliary and bank 1b/8 i/o rails; pll, converter, internal not
// - each rail has its own detector; all of them gate the main reset
// - configuration may not start until every detector has released
// - release reset after the last rail trips plus a reset delay
// - standard delay by default; an option selects the fast delay
// - configuration bank i/o supplies must be up before configuration starts
// - keep watching core and auxiliary rails in user mode
// - core or auxiliary drop in user mode reasserts the main reset
// - an i/o rail drop in user mode does not reset the device outside the instant-on watch
// - with instant-on, watch i/o drops up to 9 ms after last trip
// - with instant-on, enter configuration as soon as all rails trip
// - instant-on release loads the design from internal configuration flash
`timescale 1ns/1ps
module supply_monitor_reset_sequencer
    import supply_seq_pkg::*;
#(
    parameter logic [CNT_W-1:0] RAMP_WINDOW_CYCLES = CNT_W'(RAMP_WINDOW_CYC),
    parameter logic [CNT_W-1:0] STD_DELAY_CYCLES = CNT_W'(STD_DELAY_CYC),
    parameter logic [CNT_W-1:0] FAST_DELAY_CYCLES = CNT_W'(FAST_DELAY_CYC),
    parameter logic [CNT_W-1:0] IO_WATCH_CYCLES = CNT_W'(IO_WATCH_CYC)
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire rail_trip_t rail_trip,
    input wire logic fast_delay_sel,
    input wire logic instant_on_en,
    output logic main_reset_ff,
    output logic config_enable_ff,
    output logic load_internal_config_flash_ff,
    output logic io_hiz_ff,
    output logic ramp_fail_ff,
    output logic brownout_ff,
    output logic io_drop_ff
);

    // ----------------------------------------------------------------
    // rail combination
    // ----------------------------------------------------------------
    // pll, converter and internal digital rails have no input here at all
    logic all_tripped;
    logic core_aux_ok;
    logic io_ok;
    logic [CNT_W-1:0] dly_term;

    // every detector must release before the main reset may go
    assign all_tripped = rail_trip.core & rail_trip.aux & rail_trip.io_bank_1b & rail_trip.io_bank_8;
    assign core_aux_ok = rail_trip.core & rail_trip.aux;
    assign io_ok = rail_trip.io_bank_1b & rail_trip.io_bank_8;
    // terminal count picked by the delay option, standard unless fast is asked
    assign dly_term = fast_delay_sel ? FAST_DELAY_CYCLES : STD_DELAY_CYCLES;

    // ----------------------------------------------------------------
    // sequencer state
    // ----------------------------------------------------------------
    seq_state_t state_ff;
    seq_state_t nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [CNT_W-1:0] watch_cnt_ff;
    logic [CNT_W-1:0] nxt_watch_cnt;
    logic nxt_ramp_fail;
    logic nxt_brownout;
    logic nxt_io_drop;
    logic nxt_flash;

    // next-state logic; cnt_ff times the ramp window while waiting and the
    // reset delay afterwards, since the two never run together
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_watch_cnt = watch_cnt_ff;
        nxt_ramp_fail = ramp_fail_ff;
        nxt_brownout = brownout_ff;
        nxt_io_drop = io_drop_ff;
        nxt_flash = load_internal_config_flash_ff;
        case (state_ff)
            st_wait_rails:
            begin
                nxt_flash = 1'b0;
                if (ramp_fail_ff)
                begin
                    // missed window: stay put until an external reset
                    nxt_state = st_wait_rails;
                end
                else if (all_tripped)
                begin
                    nxt_cnt = '0;
                    if (instant_on_en)
                    begin
                        // skip the delay entirely and arm the i/o watch
                        nxt_state = st_user;
                        nxt_flash = 1'b1;
                        nxt_watch_cnt = IO_WATCH_CYCLES;
                    end
                    else
                    begin
                        nxt_state = st_delay;
                    end
                end
                else if (cnt_ff == RAMP_WINDOW_CYCLES - 1'b1)
                begin
                    nxt_ramp_fail = 1'b1;
                end
                else
                begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
            st_delay:
            begin
                if (!all_tripped)
                begin
                    // a rail fell back during the delay: start over
                    nxt_state = st_wait_rails;
                    nxt_cnt = '0;
                end
                else if (cnt_ff >= dly_term - 1'b1)
                begin
                    nxt_state = st_user;
                end
                else
                begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
            st_user:
            begin
                if (watch_cnt_ff != '0)
                begin
                    nxt_watch_cnt = watch_cnt_ff - 1'b1;
                end
                if (!core_aux_ok)
                begin
                    nxt_state = st_wait_rails;
                    nxt_brownout = 1'b1;
                    nxt_flash = 1'b0; // no flash load may be flagged while reset is back on
                    nxt_cnt = '0;
                    nxt_watch_cnt = '0;
                end
                else if (!io_ok && watch_cnt_ff != '0)
                begin
                    // only inside the instant-on watch does an i/o drop count
                    nxt_state = st_wait_rails;
                    nxt_io_drop = 1'b1;
                    nxt_flash = 1'b0;
                    nxt_cnt = '0;
                    nxt_watch_cnt = '0;
                end
                // otherwise an i/o drop is ignored
            end
            default:
            begin
                nxt_state = st_wait_rails;
                nxt_cnt = '0;
            end
        endcase
    end

    // registers; outputs decode the next state so they come straight from flops
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state_ff <= st_wait_rails;
            cnt_ff <= '0;
            watch_cnt_ff <= '0;
            ramp_fail_ff <= 1'b0;
            brownout_ff <= 1'b0;
            io_drop_ff <= 1'b0;
            load_internal_config_flash_ff <= 1'b0;
            main_reset_ff <= 1'b1;
            config_enable_ff <= 1'b0;
            io_hiz_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            watch_cnt_ff <= nxt_watch_cnt;
            ramp_fail_ff <= nxt_ramp_fail;
            brownout_ff <= nxt_brownout;
            io_drop_ff <= nxt_io_drop;
            load_internal_config_flash_ff <= nxt_flash;
            main_reset_ff <= (nxt_state != st_user);
            config_enable_ff <= (nxt_state == st_user);
            io_hiz_ff <= (nxt_state != st_user) || nxt_ramp_fail;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_hold_until_rails;
        (state_ff == st_wait_rails && !all_tripped) |=> main_reset_ff && !config_enable_ff;
    endproperty
    a_hold_until_rails: assert property (p_hold_until_rails) else $error("reset released with a rail down");

    property p_ramp_fail_hiz;
        (state_ff == st_wait_rails && !all_tripped && !ramp_fail_ff && cnt_ff == RAMP_WINDOW_CYCLES - 1'b1)
            |=> (ramp_fail_ff && io_hiz_ff) [*3];
    endproperty
    a_ramp_fail_hiz: assert property (p_ramp_fail_hiz) else $error("ramp window miss not held high-z");

    property p_release_needs_all;
        $fell(main_reset_ff) |-> $past(all_tripped);
    endproperty
    a_release_needs_all: assert property (p_release_needs_all) else $error("release without all detectors");

    property p_delay_terminal;
        (state_ff == st_delay && all_tripped && cnt_ff == dly_term - 1'b1) |=> !main_reset_ff && config_enable_ff;
    endproperty
    a_delay_terminal: assert property (p_delay_terminal) else $error("no release at delay terminal");

    property p_delay_hold;
        (state_ff == st_delay && cnt_ff < dly_term - 1'b1) |=> main_reset_ff;
    endproperty
    a_delay_hold: assert property (p_delay_hold) else $error("release before delay elapsed");

    property p_brownout;
        (state_ff == st_user && !core_aux_ok) |=> main_reset_ff && brownout_ff && io_hiz_ff;
    endproperty
    a_brownout: assert property (p_brownout) else $error("brown-out did not reassert reset");

    property p_io_drop_ignored;
        (state_ff == st_user && core_aux_ok && watch_cnt_ff == '0) |=> !main_reset_ff;
    endproperty
    a_io_drop_ignored: assert property (p_io_drop_ignored) else $error("i/o drop reset the device");

    property p_instant_on;
        (state_ff == st_wait_rails && all_tripped && instant_on_en && !ramp_fail_ff)
            |=> !main_reset_ff && load_internal_config_flash_ff && watch_cnt_ff == IO_WATCH_CYCLES;
    endproperty
    a_instant_on: assert property (p_instant_on) else $error("instant-on release wrong");

    property p_watch_io_drop;
        (state_ff == st_user && core_aux_ok && !io_ok && watch_cnt_ff != '0) |=> main_reset_ff && io_drop_ff;
    endproperty
    a_watch_io_drop: assert property (p_watch_io_drop) else $error("i/o drop in watch missed");

endmodule

// *** hdl/supply_seq_pkg.sv ***
/*
 * shared types and timing constants for the supply monitor reset sequencer.
 * assumes a single 100 MHz system clock; all rail trip inputs are already
 * synchronous to that clock.
 */
package supply_seq_pkg;

    // ----------------------------------------------------------------
    // rail trip detector bundle
    // ----------------------------------------------------------------
    // one independent detector per configuration-related rail, high = above trip
    typedef struct packed {
        logic core;        // external core rail or regulated single-supply core
        logic aux;         // auxiliary_supply_rail
        logic io_bank_1b;  // i/o supply of bank 1b
        logic io_bank_8;   // i/o supply of bank 8
    } rail_trip_t;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum {
        st_wait_rails,
        st_delay,
        st_user
    } seq_state_t;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CNT_W = 32;
    localparam int CLK_PERIOD_NS = 10;
    // supply_ramp_window, standard and fast reset delay (plain defaults)
    localparam int RAMP_WINDOW_US = 10000;
    localparam int STD_DELAY_US = 100;
    localparam int FAST_DELAY_US = 4;
    // instant-on i/o supply watch after the last rail trips
    localparam int IO_WATCH_MS = 9;

    localparam int RAMP_WINDOW_CYC = RAMP_WINDOW_US * 1000 / CLK_PERIOD_NS;
    localparam int STD_DELAY_CYC = STD_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int FAST_DELAY_CYC = FAST_DELAY_US * 1000 / CLK_PERIOD_NS;
    localparam int IO_WATCH_CYC = IO_WATCH_MS * 1000000 / CLK_PERIOD_NS;

endpackage

// *** bench/rail_detector_model.sv ***
/*
 * behavioural model of the four rail trip detectors beside the sequencer.
 * assumes the bench sets a goal level per rail; each rail ramps for a lag.
 */
`timescale 1ns/1ps
module rail_detector_model
    import supply_seq_pkg::*;
(
    input wire logic clk_sys,
    input wire rail_trip_t rail_goal,
    input wire logic [3:0] ramp_lag,
    output rail_trip_t rail_trip
);
    // ------------------------------------------------------------
    // per rail ramp
    // ------------------------------------------------------------
    logic [7:0] age_ff [4];
    logic [3:0] trip_ff;

    // each rail has its own detector; lags are staggered so the last trip varies
    always @(posedge clk_sys)
    begin
        for (int i = 0; i < 4; i++)
        begin
            if (!rail_goal[i])
            begin
                age_ff[i] <= 8'h00; // a drop is seen at once, no hysteresis
                trip_ff[i] <= 1'b0;
            end
            else
            begin
                if (age_ff[i] < 8'hff)
                    age_ff[i] <= age_ff[i] + 8'h01;
                trip_ff[i] <= (age_ff[i] >= 8'(ramp_lag) + 8'(i));
            end
        end
    end

    assign rail_trip = rail_trip_t'(trip_ff);
endmodule

// *** bench/supply_monitor_reset_sequencer_bench.sv ***
/*
 * self-checking bench for the supply monitor reset sequencer.
 * assumes short parameter values so ramp window and delays fit a quick run.
 */
`timescale 1ns/1ps
module supply_monitor_reset_sequencer_bench;
    import supply_seq_pkg::*;
    localparam int RAMP = 50;
    localparam int STD = 8;
    localparam int FAST = 2;
    localparam int WATCH = 20;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic fast_delay_sel = 1'b0;
    logic instant_on_en = 1'b0;
    logic [3:0] ramp_lag = 4'h1;
    rail_trip_t rail_goal = '0;
    rail_trip_t rail_trip;
    wire [6:0] outs;
    int error_cnt = 0;
    int compares = 0;
    int n;

    // ------------------------------------------------------------
    // clock, design and far side
    // ------------------------------------------------------------
    always #5 clk_sys = ~clk_sys;

    rail_detector_model rail_detector_model_inst (.clk_sys(clk_sys), .rail_goal(rail_goal),
        .ramp_lag(ramp_lag), .rail_trip(rail_trip));

    supply_monitor_reset_sequencer #(.RAMP_WINDOW_CYCLES(CNT_W'(RAMP)), .STD_DELAY_CYCLES(CNT_W'(STD)),
        .FAST_DELAY_CYCLES(CNT_W'(FAST)), .IO_WATCH_CYCLES(CNT_W'(WATCH)))
    supply_monitor_reset_sequencer_inst (.clk_sys(clk_sys), .reset(reset), .rail_trip(rail_trip),
        .fast_delay_sel(fast_delay_sel), .instant_on_en(instant_on_en), .main_reset_ff(outs[6]),
        .config_enable_ff(outs[5]), .load_internal_config_flash_ff(outs[4]), .io_hiz_ff(outs[3]),
        .ramp_fail_ff(outs[2]), .brownout_ff(outs[1]), .io_drop_ff(outs[0]));

    // ------------------------------------------------------------
    // reference model and helpers
    // ------------------------------------------------------------
    // mode 0 held, 1 user, 2 ramp missed, 3 brown-out, 4 i/o drop in watch
    function automatic logic [6:0] exp_out(int mode, logic inst);
        case (mode)
            1: return inst ? 7'h30 : 7'h20;
            2: return 7'h4c;
            3: return 7'h4a;
            4: return 7'h49;
            default: return 7'h48;
        endcase
    endfunction

    // edges from the sampling of the last trip until release appears;
    // instant-on releases on that very edge, otherwise the delay runs in full
    function automatic int exp_release(logic fast, logic inst);
        return inst ? 0 : (fast ? FAST : STD);
    endfunction

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %0s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // reset for four cycles with all rails down and the options applied
    task automatic start(input logic fast, input logic inst);
        @(posedge clk_sys);
        reset <= 1'b1;
        rail_goal <= '0;
        fast_delay_sel <= fast;
        instant_on_en <= inst;
        ramp_lag <= 4'($urandom_range(1, 6));
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
    endtask

    // raise all rails, then count edges from the sampling edge to release
    task automatic bring_up(output int cnt);
        int k;
        @(posedge clk_sys);
        rail_goal <= 4'hf;
        k = 0;
        do begin @(posedge clk_sys); #1; k++; end while (rail_trip !== 4'hf && k < 40);
        // this edge is the one at which the design first sees all rails up
        @(posedge clk_sys);
        #1;
        cnt = 0;
        while (outs[6] !== 1'b0 && cnt < 200)
        begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end
    endtask

    task automatic drop(input rail_trip_t g, input int wait_cyc);
        @(posedge clk_sys);
        rail_goal <= g;
        repeat (wait_cyc) @(posedge clk_sys);
        #1;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hcc8bdc85));
        // standard then fast delay; the i/o and core/aux drops follow in user mode
        for (int f = 0; f < 2; f++)
        begin
            start(f[0], 1'b0);
            chk("held", exp_out(0, 0), outs);
            bring_up(n);
            chk("release_cycles", exp_release(f[0], 0), n);
            chk("user", exp_out(1, 0), outs);
        end
        drop(4'hc, 6);
        chk("io_drop_user", exp_out(1, 0), outs);
        drop($urandom_range(0, 1) ? 4'h7 : 4'hb, 3);
        chk("brownout", exp_out(3, 0), outs);
        $display("test delays done");
        // a rail falling mid delay restarts the whole wait
        start(1'b0, 1'b0);
        bring_up(n);
        chk("release_cycles", exp_release(0, 0), n);
        // reset again from user mode, then drop a rail while the delay runs
        start(1'b0, 1'b0);
        chk("held_after_user", exp_out(0, 0), outs);
        drop(4'hf, 9);
        drop(4'hd, 2);
        chk("drop_in_delay", exp_out(0, 0), outs);
        bring_up(n);
        chk("restart_cycles", exp_release(0, 0), n);
        $display("test restart done");
        // instant-on: release at once, i/o drop resets only inside the watch
        for (int w = 0; w < 2; w++)
        begin
            start(1'b0, 1'b1);
            bring_up(n);
            chk("instant_cycles", exp_release(0, 1), n);
            chk("instant_user", exp_out(1, 1), outs);
            drop(4'hf, w * (WATCH + 5));
            drop(4'he, 3);
            chk("watch", w ? exp_out(1, 1) : exp_out(4, 0), outs);
        end
        $display("test instant done");
        // each monitored rail alone keeps reset and leads to a missed window
        for (int r = 0; r < 4; r++)
        begin
            start(1'b0, 1'b0);
            drop(4'hf & ~(4'h1 << r), RAMP - 10);
            chk("one_rail_low", exp_out(0, 0), outs);
            drop(4'hf & ~(4'h1 << r), 15);
            chk("ramp_fail", exp_out(2, 0), outs);
            drop(4'hf, STD + 10);
            chk("locked", exp_out(2, 0), outs);
        end
        $display("test ramp done");
        end_of_test();
    end

    // watchdog well beyond the roughly five hundred cycles the tests take
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        error_cnt++;
        end_of_test();
    end
endmodule
